// File: common/lsic_defs.svh
`ifndef LSIC_DEFS_SVH
`define LSIC_DEFS_SVH
`define LSIC_SLAVE_ADDR  7'h44
`define LSIC_REG_CMD     3'h0
`define LSIC_REG_CTL     3'h1
`define LSIC_REG_THR_HI  3'h2
`define LSIC_REG_THR_LO  3'h3
`define LSIC_REG_RES_LO  3'h4
`define LSIC_REG_RES_HI  3'h5
`define LSIC_REG_TMR_LO  3'h6
`define LSIC_REG_TMR_HI  3'h7
`define LSIC_CMD_EN      7
`define LSIC_CMD_PD      6
`define LSIC_CMD_EXT     5
`define LSIC_CMD_DSEL    3:2
`define LSIC_CMD_WIDTH   1:0
`define LSIC_CTL_FLAG    5
`define LSIC_CTL_GAIN    3:2
`define LSIC_CTL_PERS    1:0
`define LSIC_CTL_WMASK   8'hdf
`define LSIC_PTR_RESTART 7
`define LSIC_PTR_CLEAR   6
`define LSIC_PTR_IDX     2:0
`define LSIC_CMD_RST     8'h00
`define LSIC_CTL_RST     8'h00
`define LSIC_THR_HI_RST  8'hff
`define LSIC_THR_LO_RST  8'h00
`define LSIC_BYTE_BITS   4'h8
`define LSIC_THR_LSB     8'h00
`endif

// File: common/lsic_pkg.sv
`default_nettype none
package lsic_pkg;
  typedef enum logic [3:0] {
    LSIC_ST_IDLE = 4'h0,
    LSIC_ST_ADDR = 4'h1,
    LSIC_ST_AACK = 4'h2,
    LSIC_ST_PTR  = 4'h3,
    LSIC_ST_PACK = 4'h4,
    LSIC_ST_WDAT = 4'h5,
    LSIC_ST_WACK = 4'h6,
    LSIC_ST_RDAT = 4'h7,
    LSIC_ST_RACK = 4'h8
  } lsic_i2c_st_t;

  typedef enum logic [1:0] {
    LSIC_DSEL_D1   = 2'h0,
    LSIC_DSEL_D2   = 2'h1,
    LSIC_DSEL_DIFF = 2'h2,
    LSIC_DSEL_NOP  = 2'h3
  } lsic_dsel_t;

  typedef struct packed {
    logic [2:0]   s1;
    logic [2:0]   s2;
    logic [2:0]   s3;
    logic [2:0]   v;
    lsic_i2c_st_t st;
    logic [3:0]   bitc;
    logic [7:0]   sh;
    logic         rw;
    logic [2:0]   ptr;
    logic         sda_oe;
    logic [7:0]   cmd;
    logic [7:0]   ctl;
    logic [7:0]   thr_hi;
    logic [7:0]   thr_lo;
    logic [15:0]  res;
    logic [15:0]  tmr;
    logic         alarm;
    logic [4:0]   pcnt;
    logic         busy;
    logic         run;
    logic         phase;
    logic [15:0]  d1_hold;
    logic         req_tgl;
    logic         zero;
  } lsic_core_t;

  typedef struct packed {
    logic [2:0]  rs;
    logic [4:0]  s1;
    logic [4:0]  s2;
    logic [4:0]  s3;
    logic [4:0]  v;
    logic [16:0] cnt;
    logic        active;
    logic [15:0] cap;
    logic        done_tgl;
  } lsic_osc_t;
endpackage
`default_nettype wire

// File: rtl/lsic_top.sv
// Overview of operation
// - diode select picks diode1, diode2 or difference
// - difference mode converts diode1 then diode2
// - internal timing ends on oscillator counter completion
// - width field selects 2^16/2^12/2^8/2^4 cycles
// - external timing spans two host restart commands
// - command bit 5 selects internal or external timing
// - command bit 7 gates the conversion core
// - command bit 6 requests power-down
// - control bits 3:2 select gain range
// - interrupt pin only pulls low, never high
// - alarm on result above upper, below lower
// - persistence field needs 1/4/8/16 cycles
// - control bit 5 reads alarm state
// - upper threshold resets to 0xff
// - lower threshold resets to 0x00
// - result bytes read-only at 04 and 05
// - cycle count bytes read-only at 06, 07
// - command and control hold until overwritten
// - answer only to matching seven-bit slave address
// - pointer bit 7 restarts integration, external only
// - pointer bit 6 clears alarm and pin
// - persistence counts consecutive out-of-window results
// - threshold low byte is fixed zero
// - core enable reads 0 after reset
// - result updated after every completed integration, every second one in difference mode
`include "lsic_defs.svh"
`default_nettype none
module lsic_top (
  input  wire logic        core_clk_i,  // core clock, 20 MHz
  input  wire logic        rst_i,       // synchronous reset, high
  input  wire logic        osc_clk_i,   // integration oscillator
  input  wire logic        scl_i,       // bus clock pin
  input  wire logic        sda_i,       // bus data pin level
  output logic             sda_o,       // bus data drive value
  output logic             sda_oe_o,    // bus data pull-down enable
  output logic             int_o,       // alarm pin drive value
  output logic             int_oe_o,    // alarm pin pull-down enable
  input  wire logic [15:0] d1_count_i,  // diode1 converter count
  input  wire logic [15:0] d2_count_i,  // diode2 converter count
  output logic             adc_en_o,    // converter core enable
  output logic             pwr_dn_o,    // power-down request
  output lsic_pkg::lsic_dsel_t dsel_o,  // diode select mode
  output logic             phase_o,     // second half of difference
  output logic [1:0]       gain_o,      // gain range select
  output logic             integ_o      // integration running
);
  import lsic_pkg::*;

  lsic_core_t q, n;
  lsic_osc_t  o, on;

  // settle a synchronised bit only when the last two stages agree
  function automatic logic [4:0] filt(input logic [4:0] a, input logic [4:0] b,
                                      input logic [4:0] v);
    filt = (~(a ^ b) & a) | ((a ^ b) & v);
  endfunction

  function automatic logic [16:0] cyc_limit(input logic [1:0] w);
    case (w)
      2'h0:    cyc_limit = 17'h10000;
      2'h1:    cyc_limit = 17'h01000;
      2'h2:    cyc_limit = 17'h00100;
      default: cyc_limit = 17'h00010;
    endcase
  endfunction

  function automatic logic [15:0] res_mask(input logic [1:0] w);
    case (w)
      2'h0:    res_mask = 16'hffff;
      2'h1:    res_mask = 16'h0fff;
      2'h2:    res_mask = 16'h00ff;
      default: res_mask = 16'h000f;
    endcase
  endfunction

  function automatic logic [4:0] pers_need(input logic [1:0] p);
    case (p)
      2'h0:    pers_need = 5'h01;
      2'h1:    pers_need = 5'h04;
      2'h2:    pers_need = 5'h08;
      default: pers_need = 5'h10;
    endcase
  endfunction

  function automatic logic [7:0] rd_reg(input logic [2:0] a);
    case (a)
      `LSIC_REG_CMD:    rd_reg = q.cmd;
      `LSIC_REG_CTL:    rd_reg = {q.ctl[7:6], q.alarm, q.ctl[4:0]};
      `LSIC_REG_THR_HI: rd_reg = q.thr_hi;
      `LSIC_REG_THR_LO: rd_reg = q.thr_lo;
      `LSIC_REG_RES_LO: rd_reg = q.res[7:0];
      `LSIC_REG_RES_HI: rd_reg = q.res[15:8];
      `LSIC_REG_TMR_LO: rd_reg = q.tmr[7:0];
      default:          rd_reg = q.tmr[15:8];
    endcase
  endfunction

  logic [2:0]  nv;
  logic        scl_rise, scl_fall, bus_start, bus_stop, done_ev;
  logic        restart_ev, clear_ev, run, upd, out_win, set_alarm;
  logic [15:0] sample;
  logic [4:0]  pnext;
  logic [7:0]  rbyte;

  always_comb begin
    n          = q;
    n.s1       = {o.done_tgl, scl_i, sda_i};
    n.s2       = q.s1;
    n.s3       = q.s2;
    nv         = 3'(filt({2'b00, q.s2}, {2'b00, q.s3}, {2'b00, q.v}));
    n.v        = nv;
    scl_rise   = nv[1] & ~q.v[1];
    scl_fall   = ~nv[1] & q.v[1];
    bus_start  = nv[1] & q.v[1] & q.v[0] & ~nv[0];
    bus_stop   = nv[1] & q.v[1] & ~q.v[0] & nv[0];
    done_ev    = nv[2] ^ q.v[2];
    restart_ev = 1'b0;
    clear_ev   = 1'b0;
    rbyte      = 8'h00;
    if (scl_rise) begin
      n.bitc = q.bitc + 4'h1;
    end
    if (bus_start) begin
      n.st     = LSIC_ST_ADDR;
      n.bitc   = 4'h0;
      n.sda_oe = 1'b0;
    end else if (bus_stop) begin
      n.st     = LSIC_ST_IDLE;
      n.sda_oe = 1'b0;
    end else begin
      case (q.st)
        LSIC_ST_ADDR, LSIC_ST_PTR, LSIC_ST_WDAT: begin
          if (scl_rise) begin
            n.sh = {q.sh[6:0], nv[0]};
          end
          if (scl_fall && q.bitc == `LSIC_BYTE_BITS) begin
            n.bitc   = 4'h0;
            n.sda_oe = 1'b1;
            if (q.st == LSIC_ST_ADDR) begin
              if (q.sh[7:1] == `LSIC_SLAVE_ADDR) begin
                n.rw = q.sh[0];
                n.st = LSIC_ST_AACK;
              end else begin
                n.sda_oe = 1'b0;
                n.st     = LSIC_ST_IDLE;
              end
            end else if (q.st == LSIC_ST_PTR) begin
              n.ptr      = q.sh[`LSIC_PTR_IDX];
              restart_ev = q.sh[`LSIC_PTR_RESTART];
              clear_ev   = q.sh[`LSIC_PTR_CLEAR];
              n.st       = LSIC_ST_PACK;
            end else begin
              // read-only offsets 04 to 07 swallow the byte
              case (q.ptr)
                `LSIC_REG_CMD:    n.cmd = q.sh;
                `LSIC_REG_CTL:    n.ctl = q.sh & `LSIC_CTL_WMASK;
                `LSIC_REG_THR_HI: n.thr_hi = q.sh;
                `LSIC_REG_THR_LO: n.thr_lo = q.sh;
                default:          n.ptr = q.ptr;
              endcase
              n.ptr = q.ptr + 3'h1;
              n.st  = LSIC_ST_WACK;
            end
          end
        end
        LSIC_ST_AACK, LSIC_ST_RACK: begin
          if (scl_rise && q.st == LSIC_ST_RACK && nv[0]) begin
            n.st = LSIC_ST_IDLE; // host nack ends the read
          end else if (scl_fall) begin
            n.bitc = 4'h0;
            if (q.rw) begin
              rbyte    = rd_reg(q.ptr);
              n.sh     = rbyte;
              n.sda_oe = ~rbyte[7];
              n.ptr    = q.ptr + 3'h1;
              n.st     = LSIC_ST_RDAT;
            end else begin
              n.sda_oe = 1'b0;
              n.st     = LSIC_ST_PTR;
            end
          end
        end
        LSIC_ST_PACK, LSIC_ST_WACK: begin
          if (scl_fall) begin
            n.sda_oe = 1'b0;
            n.bitc   = 4'h0;
            n.st     = LSIC_ST_WDAT;
          end
        end
        LSIC_ST_RDAT: begin
          if (scl_fall) begin
            if (q.bitc == `LSIC_BYTE_BITS) begin
              n.sda_oe = 1'b0;
              n.bitc   = 4'h0;
              n.st     = LSIC_ST_RACK;
            end else begin
              n.sh     = {q.sh[6:0], 1'b0};
              n.sda_oe = ~q.sh[6];
            end
          end
        end
        default: n.st = LSIC_ST_IDLE;
      endcase
    end
    // integration sequencing
    run    = q.cmd[`LSIC_CMD_EN] & ~q.cmd[`LSIC_CMD_PD]
           & (q.cmd[`LSIC_CMD_DSEL] != LSIC_DSEL_NOP);
    n.run  = run; // registered copy for the oscillator side
    upd    = 1'b0;
    sample = q.res;
    if (!run) begin
      n.busy  = 1'b0;
      n.phase = 1'b0;
      n.pcnt  = 5'h00;
    end else begin
      if (q.cmd[`LSIC_CMD_EXT]) begin
        if (restart_ev) begin
          n.req_tgl = ~q.req_tgl;
          n.busy    = 1'b1;
        end
      end else if (!q.busy) begin
        n.req_tgl = ~q.req_tgl;
        n.busy    = 1'b1;
      end
      if (done_ev && q.busy) begin
        if (!q.cmd[`LSIC_CMD_EXT]) begin
          n.req_tgl = ~q.req_tgl; // next period at once so integ_o never dips
        end
        n.tmr  = o.cap;
        case (q.cmd[`LSIC_CMD_DSEL])
          LSIC_DSEL_D1: begin
            sample = d1_count_i & res_mask(q.cmd[`LSIC_CMD_WIDTH]);
            upd    = 1'b1;
          end
          LSIC_DSEL_D2: begin
            sample = d2_count_i & res_mask(q.cmd[`LSIC_CMD_WIDTH]);
            upd    = 1'b1;
          end
          default: begin
            if (!q.phase) begin
              n.d1_hold = d1_count_i;
              n.phase   = 1'b1;
            end else begin
              sample  = (q.d1_hold - d2_count_i) & res_mask(q.cmd[`LSIC_CMD_WIDTH]);
              n.phase = 1'b0;
              upd     = 1'b1;
            end
          end
        endcase
      end
    end
    if (upd) begin
      n.res = sample;
    end
    out_win   = (sample > {q.thr_hi, `LSIC_THR_LSB})
              || (sample < {q.thr_lo, `LSIC_THR_LSB});
    pnext     = q.pcnt + 5'h01;
    set_alarm = 1'b0;
    if (upd) begin
      if (out_win) begin
        if (pnext >= pers_need(q.ctl[`LSIC_CTL_PERS])) begin
          set_alarm = 1'b1;
          n.pcnt    = pers_need(q.ctl[`LSIC_CTL_PERS]);
        end else begin
          n.pcnt = pnext;
        end
      end else begin
        n.pcnt = 5'h00;
      end
    end
    n.alarm = set_alarm | (q.alarm & ~clear_ev);
    n.zero  = 1'b0;
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      q        <= '0;
      q.st     <= LSIC_ST_IDLE;
      q.cmd    <= `LSIC_CMD_RST;
      q.ctl    <= `LSIC_CTL_RST;
      q.thr_hi <= `LSIC_THR_HI_RST;
      q.thr_lo <= `LSIC_THR_LO_RST;
      q.v      <= 3'h3;
      q.s1     <= 3'h3;
      q.s2     <= 3'h3;
      q.s3     <= 3'h3;
    end else begin
      q <= n;
    end
  end

  // oscillator side: count stays stable in cap until the next done toggle
  logic [4:0] onv;
  logic       req_ev, orst;

  always_comb begin
    on      = o;
    on.rs   = {o.rs[1:0], rst_i};
    orst    = o.rs[2];
    on.s1   = {q.run, q.req_tgl, q.cmd[`LSIC_CMD_EXT], q.cmd[`LSIC_CMD_WIDTH]};
    on.s2   = o.s1;
    on.s3   = o.s2;
    onv     = filt(o.s2, o.s3, o.v);
    on.v    = onv;
    req_ev  = onv[3] ^ o.v[3];
    // stops at 2^16 so a long external period reads as full scale
    if (o.active && !o.cnt[16]) begin
      on.cnt = o.cnt + 17'h00001;
    end
    if (req_ev) begin
      if (o.active && onv[2]) begin
        on.cap      = o.cnt[16] ? 16'hffff : o.cnt[15:0];
        on.done_tgl = ~o.done_tgl;
      end
      on.cnt    = 17'h00000;
      on.active = 1'b1;
    end else if (!onv[4]) begin
      on.active = 1'b0; // core disabled: abandon the period
    end else if (o.active && !onv[2] && on.cnt >= cyc_limit(onv[1:0])) begin
      // at or past the limit: a narrower width may arrive mid-period
      on.cap      = on.cnt[16] ? 16'hffff : on.cnt[15:0];
      on.done_tgl = ~o.done_tgl;
      on.active   = 1'b0;
    end
    if (orst) begin
      on        = '0;
      on.rs     = {o.rs[1:0], rst_i};
    end
  end

  always_ff @(posedge osc_clk_i) begin
    o <= on;
  end

  assign sda_o    = q.zero;
  assign sda_oe_o = q.sda_oe;
  assign int_o    = q.zero;
  assign int_oe_o = q.alarm;
  assign adc_en_o = q.cmd[`LSIC_CMD_EN];
  assign pwr_dn_o = q.cmd[`LSIC_CMD_PD];
  assign dsel_o   = lsic_dsel_t'(q.cmd[`LSIC_CMD_DSEL]);
  assign phase_o  = q.phase;
  assign gain_o   = q.ctl[`LSIC_CTL_GAIN];
  assign integ_o  = q.busy;

  chk_thr_reset: assert property (@(posedge core_clk_i) rst_i |=>
    (q.thr_hi == `LSIC_THR_HI_RST && q.thr_lo == `LSIC_THR_LO_RST && !q.cmd[`LSIC_CMD_EN]))
    else $error("threshold or enable reset value wrong");
  chk_pin_low: assert property (@(posedge core_clk_i) disable iff (rst_i)
    !int_o && (int_oe_o == q.alarm))
    else $error("alarm pin driven high or not from alarm");
  chk_alarm_clear: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (clear_ev && !set_alarm) |=> !int_oe_o)
    else $error("alarm not cleared");
  chk_pers_fire: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (upd && out_win && pnext >= pers_need(q.ctl[`LSIC_CTL_PERS])) |=> q.alarm)
    else $error("alarm missed at persistence count");
  chk_window_reset: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (upd && !out_win) |=> (q.pcnt == 5'h00) [*2])
    else $error("in-window result kept persistence count");
  chk_res_hold: assert property (@(posedge core_clk_i) disable iff (rst_i)
    !upd |=> $stable(q.res))
    else $error("result changed without a conversion");
  chk_addr_match: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (q.st == LSIC_ST_ADDR && n.st == LSIC_ST_AACK) |-> q.sh[7:1] == `LSIC_SLAVE_ADDR)
    else $error("acknowledged a foreign address");
  chk_core_off: assert property (@(posedge core_clk_i) disable iff (rst_i)
    !q.cmd[`LSIC_CMD_EN] |=> !q.busy)
    else $error("integration while core disabled");
  chk_int_count: assert property (@(posedge osc_clk_i) disable iff (orst)
    (o.active && !req_ev && !onv[2] && on.cnt >= cyc_limit(onv[1:0])) |=> !o.active)
    else $error("internal integration overran its count");
  cov_alarm: cover property (@(posedge core_clk_i) disable iff (rst_i) $rose(q.alarm));
  cov_diff: cover property (@(posedge core_clk_i) disable iff (rst_i) upd && q.phase);
  cov_read: cover property (@(posedge core_clk_i) disable iff (rst_i) q.st == LSIC_ST_RACK);
  cov_ext: cover property (@(posedge core_clk_i) disable iff (rst_i) restart_ev && run);
endmodule
`default_nettype wire

// File: dv/lsic_host_model.sv
`include "lsic_defs.svh"
`default_nettype none
module lsic_host_model (
  input  wire logic clk_i,     // core clock, paces the bus
  input  wire logic sda_i,     // resolved data line
  output logic      scl_o,     // bus clock, host only
  output logic      sda_low_o  // host pulls data low
);
  timeunit 1ns;
  timeprecision 1ns;
  localparam int Qtr = 6;  // quarter bit, well above the pin sync lag
  int nack_cnt = 0;
  initial begin
    scl_o = 1'b1;
    sda_low_o = 1'b0;
  end
  task automatic qw();
    repeat (Qtr) @(negedge clk_i);
  endtask
  // also serves as repeated start: data released before clock rises
  task automatic start();
    qw();
    sda_low_o = 1'b0;
    qw();
    scl_o = 1'b1;
    qw();
    sda_low_o = 1'b1;
    qw();
    scl_o = 1'b0;
  endtask
  task automatic stop();
    qw();
    sda_low_o = 1'b1;
    qw();
    scl_o = 1'b1;
    qw();
    sda_low_o = 1'b0;
    qw();
  endtask
  task automatic put_bit(input logic b);
    qw();
    sda_low_o = ~b;
    qw();
    scl_o = 1'b1;
    qw();
    qw();
    scl_o = 1'b0;
  endtask
  task automatic get_bit(output logic b);
    qw();
    sda_low_o = 1'b0;
    qw();
    scl_o = 1'b1;
    qw();
    b = sda_i;
    qw();
    scl_o = 1'b0;
  endtask
  task automatic send(input logic [7:0] d);
    logic a;
    for (int i = 7; i >= 0; i--) begin
      put_bit(d[i]);
    end
    get_bit(a);
    if (a) begin
      nack_cnt++;
    end
  endtask
  task automatic ptr_wr(input logic [7:0] ptr);
    start();
    send({`LSIC_SLAVE_ADDR, 1'b0});
    send(ptr);
    stop();
  endtask
  task automatic reg_wr(input logic [7:0] ptr, input logic [7:0] d);
    start();
    send({`LSIC_SLAVE_ADDR, 1'b0});
    send(ptr);
    send(d);
    stop();
  endtask
  // byte at ptr lands in q[7:0]; last byte is refused to end the read
  task automatic rd4(input logic [7:0] ptr, output logic [31:0] q);
    logic v;
    start();
    send({`LSIC_SLAVE_ADDR, 1'b0});
    send(ptr);
    start();
    send({`LSIC_SLAVE_ADDR, 1'b1});
    for (int k = 0; k < 4; k++) begin
      for (int j = 7; j >= 0; j--) begin
        get_bit(v);
        q[8*k+j] = v;
      end
      put_bit(k == 3);
    end
    stop();
  endtask
endmodule
`default_nettype wire

// File: dv/tb_light_sensor_i2c_control.sv
`include "lsic_defs.svh"
`default_nettype none
module tb_light_sensor_i2c_control;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int CycleLimit = 50000;  // run needs roughly 31k cycles
  logic                 core_clk = 1'b0;
  logic                 osc_clk  = 1'b0;
  logic                 rst      = 1'b1;
  logic [15:0]          d1       = 16'h0000;
  logic [15:0]          d2       = 16'h0000;
  logic                 scl, sda_low, sda_line, sda_drv, sda_oe;
  logic                 int_drv, int_oe, adc_en, pwr_dn, phase, integ;
  logic [1:0]           gain;
  lsic_pkg::lsic_dsel_t dsel;
  logic [31:0]          q;
  int                   mismatches = 0;
  int                   checks     = 0;
  int                   cycles     = 0;
  // pull-up wins whenever nobody pulls the data line low
  assign sda_line = ~(sda_low | (sda_oe & ~sda_drv));
  initial begin
    forever #25 core_clk = ~core_clk;
  end
  initial begin
    #13;
    forever #40 osc_clk = ~osc_clk;
  end
  lsic_top i_lsic_top (
    .core_clk_i (core_clk),
    .rst_i      (rst),
    .osc_clk_i  (osc_clk),
    .scl_i      (scl),
    .sda_i      (sda_line),
    .sda_o      (sda_drv),
    .sda_oe_o   (sda_oe),
    .int_o      (int_drv),
    .int_oe_o   (int_oe),
    .d1_count_i (d1),
    .d2_count_i (d2),
    .adc_en_o   (adc_en),
    .pwr_dn_o   (pwr_dn),
    .dsel_o     (dsel),
    .phase_o    (phase),
    .gain_o     (gain),
    .integ_o    (integ)
  );
  lsic_host_model i_lsic_host_model (
    .clk_i     (core_clk),
    .sda_i     (sda_line),
    .scl_o     (scl),
    .sda_low_o (sda_low)
  );
  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic idle(input int n);
    repeat (n) @(negedge core_clk);
  endtask
  task automatic t_reset();
    i_lsic_host_model.rd4(8'h00, q);
    chk(q, 32'h00ff_0000);
    chk({31'h0, adc_en}, 32'h0);
    $display("test reset done");
  endtask
  task automatic t_address();
    i_lsic_host_model.start();
    i_lsic_host_model.send({7'h45, 1'b0});
    i_lsic_host_model.stop();
    chk(i_lsic_host_model.nack_cnt, 32'h1);
    i_lsic_host_model.nack_cnt = 0;
    $display("test address done");
  endtask
  task automatic t_regs();
    i_lsic_host_model.reg_wr(8'h02, 8'h5a);
    i_lsic_host_model.reg_wr(8'h03, 8'h21);
    i_lsic_host_model.reg_wr(8'h04, 8'hc3);
    i_lsic_host_model.reg_wr(8'h01, 8'h2e);
    i_lsic_host_model.rd4(8'h00, q);
    chk(q, 32'h215a_0e00);
    i_lsic_host_model.rd4(8'h04, q);
    chk(q, 32'h0);
    chk({30'h0, gain}, 32'h3);
    chk(i_lsic_host_model.nack_cnt, 32'h0);
    i_lsic_host_model.reg_wr(8'h02, 8'hff);
    i_lsic_host_model.reg_wr(8'h03, 8'h00);
    $display("test registers done");
  endtask
  // wait covers an in-flight 2^8 period before the new mode settles
  task automatic conv(input logic [7:0] cmd, input logic [15:0] a, input logic [15:0] b,
                      input logic [31:0] exp, input logic [31:0] mask);
    d1 = a;
    d2 = b;
    i_lsic_host_model.reg_wr(8'h00, cmd);
    idle(600);
    i_lsic_host_model.rd4(8'h04, q);
    chk(q & mask, exp);
    chk({29'h0, integ, dsel}, {29'h0, 1'b1, cmd[3:2]});
  endtask
  task automatic t_internal();
    conv(8'h82, 16'h0123, 16'h0000, 32'h0100_0023, 32'hffff_ffff);
    conv(8'h87, 16'h0000, 16'h1239, 32'h0010_0009, 32'hffff_ffff);
    conv(8'h8b, 16'h0009, 16'h0003, 32'h0000_0006, 32'h0000_ffff);
    $display("test internal done");
  endtask
  task automatic t_alarm();
    i_lsic_host_model.reg_wr(8'h00, 8'h00);
    idle(10);
    chk({31'h0, integ}, 32'h0);
    i_lsic_host_model.reg_wr(8'h02, 8'h01);
    i_lsic_host_model.reg_wr(8'h01, 8'h01);
    i_lsic_host_model.reg_wr(8'h00, 8'ha0);
    // first restart only opens a period; the fifth restart brings an in-window result
    for (int i = 0; i < 8; i++) begin
      d1 = (i == 4) ? 16'h0050 : 16'h0200;
      i_lsic_host_model.ptr_wr(8'h80);
    end
    idle(20);
    chk({31'h0, int_oe}, 32'h0);
    i_lsic_host_model.ptr_wr(8'h80);
    idle(20);
    chk({30'h0, int_oe, int_drv}, 32'h2);
    i_lsic_host_model.rd4(8'h00, q);
    chk(q, 32'h0001_21a0);
    i_lsic_host_model.rd4(8'h04, q);
    chk(q & 32'h0000_ffff, 32'h0200);
    i_lsic_host_model.ptr_wr(8'h40);
    idle(10);
    chk({31'h0, int_oe}, 32'h0);
    i_lsic_host_model.rd4(8'h00, q);
    chk(q, 32'h0001_01a0);
    $display("test alarm done");
  endtask
  task automatic t_power();
    i_lsic_host_model.reg_wr(8'h00, 8'h40);
    idle(10);
    chk({28'h0, adc_en, pwr_dn, integ, phase}, 32'h4);
    $display("test power done");
  endtask
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == CycleLimit) begin
      mismatches++;
      complete_run();
    end
  end
  initial begin
    repeat (12) @(negedge core_clk);
    rst = 1'b0;
    idle(8);
    t_reset();
    t_address();
    t_regs();
    t_internal();
    t_alarm();
    t_power();
    complete_run();
  end
endmodule
`default_nettype wire
